/* File: fas_regs.svh */
// pin-level constants for the flash identification host
`ifndef FAS_REGS_SVH
`define FAS_REGS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define FAS_CLK_PERIOD_NS   100
`define FAS_SETUP_NS        100
`define FAS_STROBE_NS       200
`define FAS_HOLD_NS         100
`define FAS_HV_SETTLE_NS    1000
`define FAS_SYNC_STAGES     2

// ----------------------------------------
// address field positions
// ----------------------------------------
`define FAS_ADDR_W          21
`define FAS_CODE_LSB        0
`define FAS_CODE_MSB        1
`define FAS_ZERO_PIN_BIT    6
`define FAS_HV_PIN_BIT      9
`define FAS_SECT_LSB        12
`define FAS_SECT_MSB        20

// ----------------------------------------
// data field positions and values
// ----------------------------------------
`define FAS_PROT_BIT        0
`define FAS_LOCK_BIT        7
`define FAS_LOW_BYTE_MASK   16'h00FF

// ----------------------------------------
// command sequence words
// ----------------------------------------
`define FAS_UNLOCK1_ADDR    21'h000555
`define FAS_UNLOCK2_ADDR    21'h0002AA
`define FAS_UNLOCK1_DATA    16'h00AA
`define FAS_UNLOCK2_DATA    16'h0055
`define FAS_IDENT_DATA      16'h0090
`define FAS_EXIT_DATA       16'h00F0
`define FAS_UNLOCK_STEPS    2'h2

`endif

/* File: fas_pkg.sv */
// types shared by the flash identification host
package fas_pkg;

  typedef enum logic [1:0] {
    FAS_CODE_MAKER  = 2'h0,
    FAS_CODE_PART   = 2'h1,
    FAS_CODE_PROT   = 2'h2,
    FAS_CODE_LOCK   = 2'h3
  } fas_code_t;

  typedef enum logic [5:0] {
    FAS_ST_IDLE   = 6'h01,
    FAS_ST_HV     = 6'h02,
    FAS_ST_UNLOCK = 6'h04,
    FAS_ST_READ   = 6'h08,
    FAS_ST_EXIT   = 6'h10,
    FAS_ST_DONE   = 6'h20
  } fas_state_t;

  typedef enum logic [3:0] {
    FAS_CY_IDLE   = 4'h1,
    FAS_CY_SETUP  = 4'h2,
    FAS_CY_STROBE = 4'h4,
    FAS_CY_HOLD   = 4'h8
  } fas_cyc_t;

endpackage

/* File: fas_cycle.sv */
// one asynchronous flash bus cycle, read or write
`timescale 1ns/1ns
`include "fas_regs.svh"

module fas_cycle #(
  parameter int ADDR_W = `FAS_ADDR_W
) (
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              start_in,
  input  wire logic              write_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [15:0]       wdata_in,
  input  wire logic [15:0]       dq_sync_in,
  output logic                   busy_out,
  output logic                   done_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   ce_n_out,
  output logic                   oe_n_out,
  output logic                   we_n_out,
  output logic [15:0]            dq_out,
  output logic                   dq_oe_out,
  output logic [15:0]            rdata_out
);

  // ----------------------------------------
  // cycle counts
  // ----------------------------------------
  localparam int SETUP_CYC  = (`FAS_SETUP_NS + `FAS_CLK_PERIOD_NS - 1) / `FAS_CLK_PERIOD_NS;
  localparam int STROBE_CYC = (`FAS_STROBE_NS + `FAS_CLK_PERIOD_NS - 1) / `FAS_CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (`FAS_HOLD_NS + `FAS_CLK_PERIOD_NS - 1) / `FAS_CLK_PERIOD_NS;
  // read strobe stretched so sampled data has crossed the synchroniser
  localparam int RD_CYC     = STROBE_CYC + `FAS_SYNC_STAGES;

  if (ADDR_W != `FAS_ADDR_W) begin : g_bad_width
    $error("fas_cycle: address width must match the device pins");
  end

  fas_pkg::fas_cyc_t state_r, state_nxt;
  logic [7:0]        cnt_r, cnt_nxt;
  logic              wr_r, wr_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [15:0]       wdata_r, wdata_nxt;
  logic [15:0]       rdata_r, rdata_nxt;
  logic              done_r, done_nxt;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    wr_nxt    = wr_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    done_nxt  = 1'b0;
    case (state_r)
      fas_pkg::FAS_CY_IDLE: begin
        if (start_in) begin
          wr_nxt    = write_in;
          addr_nxt  = addr_in;
          wdata_nxt = wdata_in;
          cnt_nxt   = 8'(SETUP_CYC - 1);
          state_nxt = fas_pkg::FAS_CY_SETUP;
        end
      end
      fas_pkg::FAS_CY_SETUP: begin
        if (cnt_r == 8'h00) begin
          cnt_nxt   = wr_r ? 8'(STROBE_CYC - 1) : 8'(RD_CYC - 1);
          state_nxt = fas_pkg::FAS_CY_STROBE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      fas_pkg::FAS_CY_STROBE: begin
        if (cnt_r == 8'h00) begin
          if (!wr_r) begin
            rdata_nxt = dq_sync_in;
          end
          cnt_nxt   = 8'(HOLD_CYC - 1);
          state_nxt = fas_pkg::FAS_CY_HOLD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      fas_pkg::FAS_CY_HOLD: begin
        if (cnt_r == 8'h00) begin
          done_nxt  = 1'b1;
          state_nxt = fas_pkg::FAS_CY_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        state_nxt = fas_pkg::FAS_CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= fas_pkg::FAS_CY_IDLE;
      cnt_r   <= 8'h00;
      wr_r    <= 1'b0;
      addr_r  <= '0;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      wr_r    <= wr_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      done_r  <= done_nxt;
    end
  end

  // ----------------------------------------
  // pin strobes
  // ----------------------------------------
  assign busy_out  = (state_r != fas_pkg::FAS_CY_IDLE);
  assign done_out  = done_r;
  assign addr_out  = addr_r;
  assign ce_n_out  = (state_r == fas_pkg::FAS_CY_IDLE);
  assign oe_n_out  = !((state_r == fas_pkg::FAS_CY_STROBE) && !wr_r);
  assign we_n_out  = !((state_r == fas_pkg::FAS_CY_STROBE) && wr_r);
  assign dq_out    = wdata_r;
  assign dq_oe_out = wr_r && (state_r != fas_pkg::FAS_CY_IDLE);
  assign rdata_out = rdata_r;

endmodule

/* File: fas_host.sv */
// host that reads identification codes out of a boot-sector parallel flash
`timescale 1ns/1ns
`include "fas_regs.svh"


module fas_host #(
  parameter int ADDR_W    = `FAS_ADDR_W,
  parameter int HV_SETTLE = (`FAS_HV_SETTLE_NS + `FAS_CLK_PERIOD_NS - 1) / `FAS_CLK_PERIOD_NS
) (
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              req_in,
  input  wire logic [1:0]        code_sel_in,
  input  wire logic              use_cmd_in,
  input  wire logic              word_mode_in,
  input  wire logic [8:0]        sector_select_bits_in,
  output logic                   busy_out,
  output logic                   done_out,
  output logic [15:0]            id_data_out,
  output logic                   protected_out,
  output logic                   secure_locked_out,
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic                   flash_addr_m1_out,
  output logic                   flash_byte_n_out,
  output logic                   flash_ce_n_out,
  output logic                   flash_oe_n_out,
  output logic                   flash_we_n_out,
  output logic                   identification_high_voltage_en_out,
  input  wire logic [15:0]       low_data_pins_in,
  output logic [15:0]            low_data_pins_out,
  output logic                   low_data_pins_oe_out
);

  if (ADDR_W != `FAS_ADDR_W || HV_SETTLE < 1 || HV_SETTLE > 255) begin : g_bad_param
    $error("fas_host: unsupported address width or settle count");
  end

  // ----------------------------------------
  // address and command helpers
  // ----------------------------------------
  // unused bits driven low so the device sees a clean pattern
  function automatic logic [ADDR_W-1:0] id_addr(input logic [1:0] code, input logic [8:0] sect);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[`FAS_CODE_MSB:`FAS_CODE_LSB] = code;
    a[`FAS_ZERO_PIN_BIT] = 1'b0;
    if (code == fas_pkg::FAS_CODE_PROT) begin
      a[`FAS_SECT_MSB:`FAS_SECT_LSB] = sect;
    end
    return a;
  endfunction

  function automatic logic [ADDR_W-1:0] cmd_addr(input logic [1:0] step);
    return (step == 2'h1) ? `FAS_UNLOCK2_ADDR : `FAS_UNLOCK1_ADDR;
  endfunction

  function automatic logic [15:0] cmd_data(input logic [1:0] step);
    logic [15:0] d;
    case (step)
      2'h0:    d = `FAS_UNLOCK1_DATA;
      2'h1:    d = `FAS_UNLOCK2_DATA;
      default: d = `FAS_IDENT_DATA;
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // data pin synchroniser
  // ----------------------------------------
  logic [15:0] dq_meta_r;
  logic [15:0] dq_sync_r;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dq_meta_r <= 16'h0000;
      dq_sync_r <= 16'h0000;
    end else begin
      dq_meta_r <= low_data_pins_in;
      dq_sync_r <= dq_meta_r;
    end
  end

  // ----------------------------------------
  // sequence state
  // ----------------------------------------
  fas_pkg::fas_state_t state_r, state_nxt;
  logic [1:0]          step_r, step_nxt;
  logic [7:0]          wait_r, wait_nxt;
  logic [1:0]          code_r, code_nxt;
  logic                cmd_r, cmd_nxt;
  logic                word_r, word_nxt;
  logic [8:0]          sect_r, sect_nxt;
  logic                hv_r, hv_nxt;
  logic [15:0]         data_r, data_nxt;
  logic                prot_r, prot_nxt;
  logic                lock_r, lock_nxt;
  logic                start_r, start_nxt;
  logic                cwr_r, cwr_nxt;
  logic [ADDR_W-1:0]   caddr_r, caddr_nxt;
  logic [15:0]         cdata_r, cdata_nxt;

  logic              cyc_busy;
  logic              cyc_done;
  logic [15:0]       cyc_rdata;
  logic [15:0]       rd_masked;

  // byte mode upper byte is not meaningful
  assign rd_masked = word_r ? cyc_rdata : (cyc_rdata & `FAS_LOW_BYTE_MASK);

  always_comb begin
    state_nxt = state_r;
    step_nxt  = step_r;
    wait_nxt  = wait_r;
    code_nxt  = code_r;
    cmd_nxt   = cmd_r;
    word_nxt  = word_r;
    sect_nxt  = sect_r;
    hv_nxt    = hv_r;
    data_nxt  = data_r;
    prot_nxt  = prot_r;
    lock_nxt  = lock_r;
    start_nxt = 1'b0;
    cwr_nxt   = cwr_r;
    caddr_nxt = caddr_r;
    cdata_nxt = cdata_r;
    case (state_r)
      fas_pkg::FAS_ST_IDLE: begin
        if (req_in) begin
          code_nxt = code_sel_in;
          cmd_nxt  = use_cmd_in;
          word_nxt = word_mode_in;
          sect_nxt = sector_select_bits_in;
          if (use_cmd_in) begin
            step_nxt  = 2'h0;
            start_nxt = 1'b1;
            cwr_nxt   = 1'b1;
            caddr_nxt = cmd_addr(2'h0);
            cdata_nxt = cmd_data(2'h0);
            state_nxt = fas_pkg::FAS_ST_UNLOCK;
          end else begin
            // raise high voltage before the read
            hv_nxt    = 1'b1;
            wait_nxt  = 8'(HV_SETTLE - 1);
            state_nxt = fas_pkg::FAS_ST_HV;
          end
        end
      end
      fas_pkg::FAS_ST_HV: begin
        if (wait_r == 8'h00) begin
          // code placed on the pins, sector only for the protection code
          start_nxt = 1'b1;
          cwr_nxt   = 1'b0;
          caddr_nxt = id_addr(code_r, sect_r);
          state_nxt = fas_pkg::FAS_ST_READ;
        end else begin
          wait_nxt = wait_r - 8'h01;
        end
      end
      fas_pkg::FAS_ST_UNLOCK: begin
        if (cyc_done) begin
          start_nxt = 1'b1;
          if (step_r == `FAS_UNLOCK_STEPS) begin
            cwr_nxt   = 1'b0;
            caddr_nxt = id_addr(code_r, sect_r);
            state_nxt = fas_pkg::FAS_ST_READ;
          end else begin
            step_nxt  = step_r + 2'h1;
            caddr_nxt = cmd_addr(step_r + 2'h1);
            cdata_nxt = cmd_data(step_r + 2'h1);
          end
        end
      end
      fas_pkg::FAS_ST_READ: begin
        if (cyc_done) begin
          data_nxt = rd_masked;
          prot_nxt = (code_r == fas_pkg::FAS_CODE_PROT) && cyc_rdata[`FAS_PROT_BIT];
          lock_nxt = (code_r == fas_pkg::FAS_CODE_LOCK) && cyc_rdata[`FAS_LOCK_BIT];
          state_nxt = fas_pkg::FAS_ST_EXIT;
          if (cmd_r) begin
            // exit command back to array read
            start_nxt = 1'b1;
            cwr_nxt   = 1'b1;
            caddr_nxt = '0;
            cdata_nxt = `FAS_EXIT_DATA;
          end else begin
            // dropping the high voltage ends identification
            hv_nxt   = 1'b0;
            wait_nxt = 8'(HV_SETTLE - 1);
          end
        end
      end
      fas_pkg::FAS_ST_EXIT: begin
        if (cmd_r) begin
          if (cyc_done) begin
            state_nxt = fas_pkg::FAS_ST_DONE;
          end
        end else if (wait_r == 8'h00) begin
          state_nxt = fas_pkg::FAS_ST_DONE;
        end else begin
          wait_nxt = wait_r - 8'h01;
        end
      end
      fas_pkg::FAS_ST_DONE: begin
        state_nxt = fas_pkg::FAS_ST_IDLE;
      end
      default: begin
        hv_nxt    = 1'b0;
        state_nxt = fas_pkg::FAS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= fas_pkg::FAS_ST_IDLE;
      step_r  <= 2'h0;
      wait_r  <= 8'h00;
      code_r  <= 2'h0;
      cmd_r   <= 1'b0;
      word_r  <= 1'b1;
      sect_r  <= 9'h000;
      hv_r    <= 1'b0;
      data_r  <= 16'h0000;
      prot_r  <= 1'b0;
      lock_r  <= 1'b0;
      start_r <= 1'b0;
      cwr_r   <= 1'b0;
      caddr_r <= '0;
      cdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      wait_r  <= wait_nxt;
      code_r  <= code_nxt;
      cmd_r   <= cmd_nxt;
      word_r  <= word_nxt;
      sect_r  <= sect_nxt;
      hv_r    <= hv_nxt;
      data_r  <= data_nxt;
      prot_r  <= prot_nxt;
      lock_r  <= lock_nxt;
      start_r <= start_nxt;
      cwr_r   <= cwr_nxt;
      caddr_r <= caddr_nxt;
      cdata_r <= cdata_nxt;
    end
  end

  // ----------------------------------------
  // bus cycle engine
  // ----------------------------------------
  // read strobes: chip and output enable low, write enable high
  fas_cycle #(
    .ADDR_W (ADDR_W)
  ) u_cycle (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .start_in    (start_r),
    .write_in    (cwr_r),
    .addr_in     (caddr_r),
    .wdata_in    (cdata_r),
    .dq_sync_in  (dq_sync_r),
    .busy_out    (cyc_busy),
    .done_out    (cyc_done),
    .addr_out    (flash_addr_out),
    .ce_n_out    (flash_ce_n_out),
    .oe_n_out    (flash_oe_n_out),
    .we_n_out    (flash_we_n_out),
    .dq_out      (low_data_pins_out),
    .dq_oe_out   (low_data_pins_oe_out),
    .rdata_out   (cyc_rdata)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // width select; minus-one bit held low so byte reads take the even byte
  assign flash_byte_n_out                   = word_r;
  assign flash_addr_m1_out                  = 1'b0;
  // command path never raises the high voltage
  assign identification_high_voltage_en_out = hv_r && !cmd_r;
  assign busy_out          = (state_r != fas_pkg::FAS_ST_IDLE) || cyc_busy;
  assign done_out          = (state_r == fas_pkg::FAS_ST_DONE);
  assign id_data_out       = data_r;
  assign protected_out     = prot_r;
  assign secure_locked_out = lock_r;

endmodule

/* File: fas_host_asserts.sv */
// pin-level assertions for the flash identification host
`timescale 1ns/1ns

module fas_host_asserts #(
  parameter int ADDR_W = 21
) (
  input wire logic              core_clk_in,
  input wire logic              reset_n_in,
  input wire logic              done_out,
  input wire logic [15:0]       id_data_out,
  input wire logic              protected_out,
  input wire logic              secure_locked_out,
  input wire logic [ADDR_W-1:0] flash_addr_out,
  input wire logic              flash_addr_m1_out,
  input wire logic              flash_byte_n_out,
  input wire logic              flash_ce_n_out,
  input wire logic              flash_oe_n_out,
  input wire logic              flash_we_n_out,
  input wire logic              identification_high_voltage_en_out,
  input wire logic              low_data_pins_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------
  // strobe sequences
  // ----------------------------------------
  sequence s_read_strobe;
    (identification_high_voltage_en_out && !flash_oe_n_out) [*4];
  endsequence
  sequence s_hold_hv;
    flash_oe_n_out && !flash_ce_n_out && identification_high_voltage_en_out;
  endsequence
  sequence s_write_strobe;
    !flash_we_n_out [*2] ##1 flash_we_n_out;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_read_strobes: assert property (!flash_oe_n_out |-> flash_we_n_out && !flash_ce_n_out && !low_data_pins_oe_out)
    else $error("read strobe seen with write strobe or bus drive");
  a_hv_pin_levels: assert property (identification_high_voltage_en_out |-> !flash_addr_out[9] && flash_we_n_out)
    else $error("high voltage applied with pin nine logic high or a write");
  a_hv_whole_read: assert property ($fell(flash_oe_n_out) && identification_high_voltage_en_out |-> s_read_strobe ##1 s_hold_hv)
    else $error("high voltage not held across the whole read");
  a_unused_low: assert property (!flash_oe_n_out |-> flash_addr_out[11:10] == 2'h0 && flash_addr_out[8:2] == 7'h00)
    else $error("unused or pin six address bits high during a read");
  a_write_plain: assert property (!flash_we_n_out |-> !identification_high_voltage_en_out && low_data_pins_oe_out && !flash_ce_n_out)
    else $error("command write with high voltage or without bus drive");
  a_write_width: assert property ($fell(flash_we_n_out) |-> s_write_strobe)
    else $error("command write strobe not two cycles");
  // bound covers the default settle of ten cycles with margin
  a_hv_exit_done: assert property ($fell(identification_high_voltage_en_out) |-> ##[1:40] done_out)
    else $error("no completion after high voltage removed");
  a_upper_masked: assert property (done_out && !flash_byte_n_out |-> id_data_out[15:8] == 8'h00)
    else $error("upper byte not cleared in byte mode");
  a_prot_bit: assert property (done_out && protected_out |-> id_data_out[7:0] == 8'h01)
    else $error("protected flag without 01h status");
  a_lock_bit: assert property (done_out && secure_locked_out |-> id_data_out[7:0] == 8'h99)
    else $error("lock flag without 99h indicator");
  a_half_addr_low: assert property (!flash_ce_n_out |-> !flash_addr_m1_out)
    else $error("half-word address pin high during a cycle");
endmodule

bind fas_host fas_host_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .core_clk_in, .reset_n_in, .done_out, .id_data_out, .protected_out, .secure_locked_out, .flash_addr_out,
  .flash_addr_m1_out, .flash_byte_n_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out,
  .identification_high_voltage_en_out, .low_data_pins_oe_out);

/* File: fas_flash_model.sv */
// behavioural boot-sector flash answering identification reads
`timescale 1ns/1ns

// identity parameters below are arbitrary values, not those of any real part
module fas_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3C,
  parameter logic [7:0] PART_LO    = 8'h5A,
  parameter logic [7:0] PART_HI    = 8'h7E,
  parameter logic [5:0] PROT_TOP   = 6'h2C
) (
  input  wire logic [20:0] addr_in,
  input  wire logic        byte_n_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        hv_en_in,
  input  wire logic        secure_locked_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out
);
  logic [1:0]  step_r   = 2'h0;
  logic        cmd_id_r = 1'b0;
  logic [15:0] last_r   = 16'h0000;
  logic [15:0] id_v;
  logic [15:0] rd_v;

  // ----------------------------------------
  // command interpreter
  // ----------------------------------------
  // command entry and exit
  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      if (dq_in[7:0] == 8'hF0) begin
        cmd_id_r <= 1'b0;
        step_r   <= 2'h0;
      end else if (step_r == 2'h0 && addr_in[10:0] == 11'h555 && dq_in[7:0] == 8'hAA) begin
        step_r <= 2'h1;
      end else if (step_r == 2'h1 && addr_in[10:0] == 11'h2AA && dq_in[7:0] == 8'h55) begin
        step_r <= 2'h2;
      end else if (step_r == 2'h2 && addr_in[10:0] == 11'h555 && dq_in[7:0] == 8'h90) begin
        cmd_id_r <= 1'b1;
        step_r   <= 2'h0;
      end else begin
        step_r <= 2'h0;
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // code decode, 64 Kbyte groups, other bits ignored
  always_comb begin
    case (addr_in[1:0])
      2'h0:    id_v = {8'hC3, MAKER_CODE};
      2'h1:    id_v = {PART_HI, PART_LO};
      2'h2:    id_v = {8'hC3, 7'h00, addr_in[20:15] == PROT_TOP};
      default: id_v = {8'hC3, secure_locked_in, 7'h19};
    endcase
    // upper pins meaningless in byte mode
    if (!byte_n_in) begin
      id_v[15:8] = ~last_r[15:8];
    end
    rd_v = ((hv_en_in && !addr_in[6]) || cmd_id_r) ? id_v : {addr_in[7:0], ~addr_in[7:0]};
  end

  // released bus shows the inverse of the last value, never a held copy
  always @(posedge oe_n_in) begin
    last_r <= rd_v;
  end
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_v : ~last_r;
endmodule

/* File: fas_host_bench.sv */
// self-checking bench for the flash identification host
`timescale 1ns/1ns

module fas_host_bench;
  // arbitrary identity values, not those of any real part
  localparam logic [7:0] MAKER   = 8'h3C;
  localparam logic [7:0] PART_LO = 8'h5A;
  localparam logic [7:0] PART_HI = 8'h7E;

  logic        core_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        req_in = 1'b0;
  logic [1:0]  code_sel_in = 2'h0;
  logic        use_cmd_in = 1'b0;
  logic        word_mode_in = 1'b1;
  logic [8:0]  sector_select_bits_in = 9'h000;
  logic        locked = 1'b1;
  logic        busy_out, done_out, protected_out, secure_locked_out, flash_addr_m1_out, flash_byte_n_out;
  logic        flash_ce_n_out, flash_oe_n_out, flash_we_n_out, identification_high_voltage_en_out;
  logic        low_data_pins_oe_out;
  logic [15:0] id_data_out, low_data_pins_out, low_data_pins_in, flash_dq;
  logic [20:0] flash_addr_out;
  int          err_total = 0;
  int          comparisons = 0;

  assign low_data_pins_in = low_data_pins_oe_out ? low_data_pins_out : flash_dq;

  fas_host #(.HV_SETTLE(1)) DUT (
    .core_clk_in, .reset_n_in, .req_in, .code_sel_in, .use_cmd_in, .word_mode_in, .sector_select_bits_in,
    .busy_out, .done_out, .id_data_out, .protected_out, .secure_locked_out, .flash_addr_out, .flash_addr_m1_out,
    .flash_byte_n_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out, .identification_high_voltage_en_out,
    .low_data_pins_in, .low_data_pins_out, .low_data_pins_oe_out);

  fas_flash_model #(.MAKER_CODE(MAKER), .PART_LO(PART_LO), .PART_HI(PART_HI), .PROT_TOP(6'h2C)) u_flash (
    .addr_in(flash_addr_out), .byte_n_in(flash_byte_n_out), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .hv_en_in(identification_high_voltage_en_out), .secure_locked_in(locked),
    .dq_in(low_data_pins_in), .dq_out(flash_dq));

  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic launch(input logic [1:0] c, input logic cmd, input logic w, input logic [8:0] s);
    code_sel_in = c;
    use_cmd_in = cmd;
    word_mode_in = w;
    sector_select_bits_in = s;
    req_in = 1'b1;
    @(posedge core_clk_in);
    #10 req_in = 1'b0;
  endtask

  // extra edge afterwards so the next request meets an idle engine
  task automatic wait_done();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 300) begin
      @(posedge core_clk_in);
      #10;
      n++;
    end
    chk("done pulse", 16'(done_out), 16'h0001);
    @(posedge core_clk_in);
    #10;
  endtask

  task automatic id_read(input logic [1:0] c, input logic cmd, input logic w, input logic [8:0] s);
    launch(c, cmd, w, s);
    wait_done();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_codes();
    logic [7:0] exp_lo [4];
    exp_lo = '{MAKER, PART_LO, 8'h00, 8'h99};
    locked = 1'b1;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        id_read(2'(c), 1'(m), 1'b1, 9'h000);
        chk("id low byte", 16'(id_data_out[7:0]), 16'(exp_lo[c]));
        if (c == 1) chk("part word", id_data_out, {PART_HI, PART_LO});
        if (c == 3) chk("lock flag", 16'(secure_locked_out), 16'h0001);
        chk("high voltage off", 16'(identification_high_voltage_en_out), 16'h0000);
        chk("command mode left", 16'(u_flash.cmd_id_r), 16'h0000);
      end
    end
  endtask

  task automatic t_protect();
    logic [8:0] s_tab [5];
    logic       p_tab [5];
    s_tab = '{9'h165, 9'h160, 9'h168, 9'h1FF, 9'h000};
    p_tab = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 5; i++) begin
        id_read(2'h2, 1'(m), 1'b1, s_tab[i]);
        chk("protect status", 16'(id_data_out[7:0]), 16'(p_tab[i]));
        chk("protect flag", 16'(protected_out), 16'(p_tab[i]));
      end
    end
  endtask

  task automatic t_byte();
    for (int m = 0; m < 2; m++) begin
      id_read(2'h1, 1'(m), 1'b0, 9'h000);
      chk("part byte mode", id_data_out, {8'h00, PART_LO});
      chk("width pin byte", 16'(flash_byte_n_out), 16'h0000);
    end
    id_read(2'h1, 1'b0, 1'b1, 9'h000);
    chk("width pin word", 16'(flash_byte_n_out), 16'h0001);
  endtask

  // second request while busy must be dropped, then back to back
  task automatic t_refuse();
    locked = 1'b0;
    launch(2'h3, 1'b0, 1'b1, 9'h000);
    repeat (3) @(posedge core_clk_in);
    #10;
    code_sel_in = 2'h0;
    req_in = 1'b1;
    @(posedge core_clk_in);
    #10 req_in = 1'b0;
    chk("busy while reading", 16'(busy_out), 16'h0001);
    wait_done();
    chk("idle after read", 16'(busy_out), 16'h0000);
    chk("unlocked indicator", 16'(id_data_out[7:0]), 16'h0019);
    chk("unlocked flag", 16'(secure_locked_out), 16'h0000);
    id_read(2'h0, 1'b1, 1'b1, 9'h000);
    chk("maker after refuse", 16'(id_data_out[7:0]), 16'(MAKER));
  endtask

  // reset in mid-read must drop high voltage and strobes at once
  task automatic t_reset();
    launch(2'h0, 1'b0, 1'b0, 9'h000);
    repeat (4) @(posedge core_clk_in);
    #10 reset_n_in = 1'b0;
    #10;
    chk("hv after reset", 16'(identification_high_voltage_en_out), 16'h0000);
    chk("pins after reset", 16'({busy_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_byte_n_out}), 16'h000F);
    @(posedge core_clk_in);
    #10 reset_n_in = 1'b1;
    id_read(2'h0, 1'b0, 1'b1, 9'h000);
    chk("maker after reset", 16'(id_data_out[7:0]), 16'(MAKER));
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk_in);
    #10 reset_n_in = 1'b1;
    @(posedge core_clk_in);
    #10;
    t_codes();
    t_protect();
    t_byte();
    t_refuse();
    t_reset();
    close_out();
  end

  // about 25 reads of under 60 cycles each; limit leaves wide margin
  initial begin
    #2000000;
    err_total++;
    close_out();
  end
endmodule
